// file: hdl/pfce_pkg.sv
// Package: pin timing, command codes and request types for the flash host controller
package pfce_pkg;
  localparam int          PFCE_AW          = 19;
  localparam int          PFCE_DW          = 16;
  localparam int          PFCE_CLK_MHZ     = 10;
  // Pin phase lengths in ns (program time in us), turned into clock counts (least times round up)
  localparam int          PFCE_T_WE_NS     = 100;
  localparam int          PFCE_T_SETUP_NS  = 100;
  localparam int          PFCE_T_RD_NS     = 200;
  localparam int          PFCE_T_RC_NS     = 100;
  localparam int          PFCE_T_SETTLE_NS = 1000;
  localparam int          PFCE_T_PROG_US   = 20;
  localparam int          PFCE_WE_CYC      = (PFCE_T_WE_NS * PFCE_CLK_MHZ + 999) / 1000;
  localparam int          PFCE_SETUP_CYC   = (PFCE_T_SETUP_NS * PFCE_CLK_MHZ + 999) / 1000;
  localparam int          PFCE_RD_CYC      = (PFCE_T_RD_NS * PFCE_CLK_MHZ + 999) / 1000;
  localparam int          PFCE_RC_CYC      = (PFCE_T_RC_NS * PFCE_CLK_MHZ + 999) / 1000;
  localparam int          PFCE_SETTLE_CYC  = (PFCE_T_SETTLE_NS * PFCE_CLK_MHZ + 999) / 1000;
  localparam int          PFCE_PROG_CYC    = PFCE_T_PROG_US * PFCE_CLK_MHZ;
  localparam int          PFCE_POLL_MAX    = 2000000;
  // Unlock addresses and codes
  localparam logic [15:0] PFCE_ADDR_A      = 16'h5555;
  localparam logic [15:0] PFCE_ADDR_B      = 16'h2aaa;
  localparam logic [7:0]  PFCE_CODE_AA     = 8'haa;
  localparam logic [7:0]  PFCE_CODE_55     = 8'h55;
  localparam logic [7:0]  PFCE_CODE_PROG   = 8'ha0;
  localparam logic [7:0]  PFCE_CODE_ERASE  = 8'h80;
  localparam logic [7:0]  PFCE_CODE_SECT   = 8'h30;
  localparam logic [7:0]  PFCE_CODE_BLOCK  = 8'h50;
  localparam logic [7:0]  PFCE_CODE_CHIP   = 8'h10;
  localparam logic [7:0]  PFCE_CODE_QUERY  = 8'h98;
  localparam logic [7:0]  PFCE_CODE_EXIT   = 8'hf0;
  localparam logic [7:0]  PFCE_HI_BYTE     = 8'h00;
  localparam int          PFCE_DQ_POLL     = 7;
  localparam int          PFCE_DQ_TOGGLE   = 6;

  typedef enum logic [2:0] {
    PFCE_OP_READ, PFCE_OP_PROG, PFCE_OP_SECT, PFCE_OP_BLOCK,
    PFCE_OP_CHIP, PFCE_OP_QUERY, PFCE_OP_EXIT
  } pfce_op_t;

  typedef struct packed {
    pfce_op_t            op;
    logic [PFCE_AW-1:0]  addr;
    logic [PFCE_DW-1:0]  data;
  } pfce_req_t;

  typedef struct packed {
    logic                ok;
    logic                timeout;
    logic [PFCE_DW-1:0]  data;
  } pfce_rsp_t;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [PFCE_AW-1:0]  addr;
  } pfce_pins_t;
endpackage : pfce_pkg

// file: hdl/pfce_host.sv
// Host controller that drives the parallel flash pins for read, program, erase, query
// Operation
// [RL1] Address is steady before write strobe falls; device latches it there.
// [RL2] Data is steady until after write strobe rises; device latches it there.
// [RL3] Host drives data lines only with output gate high; reads with it low.
// [RL4] Program is three unlock writes then address/data write; done within 20 us.
// [RL5] Host only programs words in sectors already erased; caller's duty.
// [RL6] No command is written while a program or erase is still running. Host: after a poll timeout it goes idle and accepts any request.
// [RL7] Sector erase: six writes, last carries 30H at the sector address.
// [RL8] Block erase: six writes, last carries 50H at the block address.
// [RL9] Sixth write carries erase address at fall, code at rise of strobe.
// [RL10] Chip erase: six writes ending with 10H at address 5555H.
// [RL11] Chip erase starts at rise of sixth strobe; polling starts after it.
// [RL12] Bit 7 reads inverse data during program, true data when done.
// [RL13] After program completion, full word valid only after 1 us more.
// [RL14] Bit 7 reads zero during erase and one when done.
// [RL15] Status polling begins only after the last write pulse rises.
// [RL16] Bit 6 flips on each read while busy; stops when done.
// [RL17] On doubtful status, read twice more; done only if both agree.
// [RL18] Write strobe pulses are far longer than 5 ns.
// [RL19] Writes keep output gate high, chip select and strobe low together.
// [RL20] Host never writes invalid words inside an unlock sequence.
// [RL21] Data bits 15 to 8 are driven to zero during unlock writes.
// [RL22] Query entry is three writes ending 98H at 5555H; exit command leaves.
// [RL23] Exit command is never sent while program or erase runs. Host: after a poll timeout it goes idle and accepts an exit request.
// [RL24] After completion the device is back in array read; no command sent.
`timescale 1ns/1ns
module pfce_host
  import pfce_pkg::*;
#(
  parameter int POLL_MAX = PFCE_POLL_MAX
) (
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire pfce_req_t          req_in,
  input  wire logic               req_valid_in,
  output      logic               req_ready_out,
  output      pfce_rsp_t          rsp_out,
  output      logic               rsp_valid_out,
  output      pfce_pins_t         pins_out,
  output      logic [PFCE_DW-1:0] data_lines_out,
  output      logic               data_lines_oe_out,
  input  wire logic [PFCE_DW-1:0] data_lines_in
);
  typedef enum logic [2:0] {
    PFCE_IDLE, PFCE_W_SET, PFCE_W_LOW, PFCE_W_HOLD, PFCE_R_LOW, PFCE_R_GAP, PFCE_SETTLE
  } pfce_state_t;

  pfce_state_t         state;
  pfce_req_t           cur;
  logic [2:0]          step;
  logic [2:0]          last_step;
  logic [21:0]         cnt;
  logic [21:0]         polls;
  logic                polling;
  logic                have_prev;
  logic                agree;
  logic [PFCE_DW-1:0]  prev;
  logic [PFCE_DW-1:0]  sync1;
  logic [PFCE_DW-1:0]  sync2;

  function automatic logic [PFCE_DW-1:0] cmd_word(input logic [7:0] c);
    return {PFCE_HI_BYTE, c}; // RL21
  endfunction : cmd_word

  function automatic logic [2:0] seq_len(input pfce_op_t op);
    case (op)
      PFCE_OP_READ:  seq_len = 3'd0;
      PFCE_OP_EXIT:  seq_len = 3'd0;
      PFCE_OP_PROG:  seq_len = 3'd3;
      PFCE_OP_QUERY: seq_len = 3'd2;
      default:       seq_len = 3'd5;
    endcase
  endfunction : seq_len

  // Unlock word table per step; final write holds the op target
  logic [PFCE_AW-1:0] w_addr;
  logic [PFCE_DW-1:0] w_data;
  logic               is_erase;
  logic               final_w;
  logic [7:0]         fin_code;
  assign is_erase = (cur.op == PFCE_OP_SECT) || (cur.op == PFCE_OP_BLOCK) ||
                    (cur.op == PFCE_OP_CHIP);
  assign final_w  = (step == last_step);
  assign fin_code = (cur.op == PFCE_OP_SECT)  ? PFCE_CODE_SECT :  // RL7
                    (cur.op == PFCE_OP_BLOCK) ? PFCE_CODE_BLOCK : // RL8
                    (cur.op == PFCE_OP_CHIP)  ? PFCE_CODE_CHIP :  // RL10
                    (cur.op == PFCE_OP_QUERY) ? PFCE_CODE_QUERY : // RL22
                    PFCE_CODE_EXIT;                               // RL23
  always_comb begin
    w_addr = {{(PFCE_AW-16){1'b0}}, PFCE_ADDR_A};
    w_data = cmd_word(PFCE_CODE_AA);
    if (step == 3'd1 || step == 3'd4) begin
      w_addr = {{(PFCE_AW-16){1'b0}}, PFCE_ADDR_B};
      w_data = cmd_word(PFCE_CODE_55);
    end else if (step == 3'd2 && !final_w) begin
      w_data = cmd_word(cur.op == PFCE_OP_PROG ? PFCE_CODE_PROG : PFCE_CODE_ERASE);
    end
    if (final_w) begin
      if (cur.op == PFCE_OP_PROG) begin // RL4
        w_addr = cur.addr;
        w_data = cur.data;
      end else if (cur.op == PFCE_OP_SECT || cur.op == PFCE_OP_BLOCK) begin // RL9
        w_addr = cur.addr;
        w_data = cmd_word(fin_code);
      end else begin
        w_data = cmd_word(fin_code);
      end
    end
  end

  // Status decode on the synchronised read word
  logic bit7_done;
  logic toggle_still;
  logic status_done;
  assign bit7_done    = is_erase ? sync2[PFCE_DQ_POLL] :                       // RL14
                        (sync2[PFCE_DQ_POLL] == cur.data[PFCE_DQ_POLL]);       // RL12
  assign toggle_still = have_prev && (sync2[PFCE_DQ_TOGGLE] == prev[PFCE_DQ_TOGGLE]); // RL16
  assign status_done  = bit7_done && toggle_still;

  always_ff @(posedge clk_in) begin
    sync1 <= data_lines_in;
    sync2 <= sync1;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state             <= PFCE_IDLE;
      cur               <= '0;
      step              <= 3'd0;
      last_step         <= 3'd0;
      cnt               <= '0;
      polls             <= '0;
      polling           <= 1'b0;
      have_prev         <= 1'b0;
      agree             <= 1'b0;
      prev              <= '0;
      req_ready_out     <= 1'b0;
      rsp_out           <= '0;
      rsp_valid_out     <= 1'b0;
      pins_out          <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
      data_lines_out    <= '0;
      data_lines_oe_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        PFCE_IDLE: begin
          req_ready_out <= 1'b1;
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'b0;
            cur           <= req_in;
            step          <= 3'd0;
            last_step     <= seq_len(req_in.op);
            polling       <= 1'b0;
            have_prev     <= 1'b0;
            agree         <= 1'b0;
            polls         <= '0;
            pins_out.addr <= req_in.addr;
            pins_out.ce_n <= 1'b0;
            // Extra cycle: address and select settle before the strobe falls
            cnt           <= 22'(PFCE_SETUP_CYC) + 22'd1; // RL1
            state         <= (req_in.op == PFCE_OP_READ) ? PFCE_R_LOW : PFCE_W_SET;
          end
        end
        PFCE_W_SET: begin // RL1 RL19
          pins_out.oe_n     <= 1'b1;
          pins_out.addr     <= w_addr;
          data_lines_out    <= w_data;
          data_lines_oe_out <= 1'b1; // RL3
          pins_out.ce_n     <= 1'b0;
          if (cnt <= 22'd1) begin
            pins_out.we_n <= 1'b0;
            cnt           <= 22'(PFCE_WE_CYC);
            state         <= PFCE_W_LOW;
          end else begin
            cnt <= cnt - 22'd1;
          end
        end
        PFCE_W_LOW: begin // RL18
          if (cnt <= 22'd1) begin
            pins_out.we_n <= 1'b1; // RL2 RL11
            cnt           <= 22'(PFCE_SETUP_CYC);
            state         <= PFCE_W_HOLD;
          end else begin
            cnt <= cnt - 22'd1;
          end
        end
        PFCE_W_HOLD: begin // RL2
          if (cnt <= 22'd1) begin
            data_lines_oe_out <= 1'b0;
            pins_out.ce_n     <= 1'b1;
            if (!final_w) begin // RL20
              step  <= step + 3'd1;
              cnt   <= 22'(PFCE_SETUP_CYC) + 22'd1; // RL1
              state <= PFCE_W_SET;
            end else if (cur.op == PFCE_OP_PROG || is_erase) begin // RL15
              polling       <= 1'b1; // RL6
              pins_out.addr <= cur.addr;
              cnt           <= 22'(PFCE_RC_CYC);
              state         <= PFCE_R_GAP;
            end else begin // RL22 RL23
              rsp_out       <= '{ok: 1'b1, timeout: 1'b0, data: '0};
              rsp_valid_out <= 1'b1;
              state         <= PFCE_IDLE;
            end
          end else begin
            cnt <= cnt - 22'd1;
          end
        end
        PFCE_R_LOW: begin // RL3
          data_lines_oe_out <= 1'b0;
          pins_out.ce_n     <= 1'b0;
          pins_out.oe_n     <= 1'b0;
          if (cnt <= 22'd1 && !pins_out.oe_n) begin
            cnt <= 22'(PFCE_RD_CYC);
            if (cnt == 22'd1 && state == PFCE_R_LOW) begin
              pins_out.oe_n <= 1'b1;
              pins_out.ce_n <= 1'b1;
              state         <= PFCE_R_GAP;
              cnt           <= 22'(PFCE_RC_CYC) + 22'd1;
            end
          end else if (!pins_out.oe_n) begin
            cnt <= cnt - 22'd1;
          end else begin
            cnt <= 22'(PFCE_RD_CYC);
          end
        end
        PFCE_R_GAP: begin
          // One extra cycle only: later the synchroniser holds the released bus
          if (cnt > 22'd1) begin
            cnt <= cnt - 22'd1;
          end else if (!polling) begin
            rsp_out       <= '{ok: 1'b1, timeout: 1'b0, data: sync2};
            rsp_valid_out <= 1'b1;
            state         <= PFCE_IDLE;
          end else begin
            if (have_prev) begin
              polls <= polls + 22'd1;
            end
            have_prev <= 1'b1;
            prev      <= sync2;
            if (have_prev && status_done && agree) begin // RL17
              cnt   <= 22'(PFCE_SETTLE_CYC);
              state <= PFCE_SETTLE; // RL13
            end else if (polls >= 22'(POLL_MAX)) begin
              rsp_out       <= '{ok: 1'b0, timeout: 1'b1, data: sync2};
              rsp_valid_out <= 1'b1;
              state         <= PFCE_IDLE;
            end else begin
              agree         <= have_prev && status_done;
              pins_out.ce_n <= 1'b0;
              cnt           <= 22'(PFCE_RD_CYC);
              state         <= PFCE_R_LOW;
            end
          end
        end
        PFCE_SETTLE: begin // RL13 RL24
          if (cnt <= 22'd1) begin
            rsp_out       <= '{ok: 1'b1, timeout: 1'b0, data: '0};
            rsp_valid_out <= 1'b1;
            state         <= PFCE_IDLE;
          end else begin
            cnt <= cnt - 22'd1;
          end
        end
        default: begin
          state <= PFCE_IDLE;
        end
      endcase
    end
  end
endmodule : pfce_host

// file: tb/pfce_host_properties.sv
// Checker: pin and handshake properties of the flash host controller
`timescale 1ns/1ns
module pfce_host_properties
  import pfce_pkg::*;
#(
  parameter int POLL_MAX = 50
) (
  input wire logic               clk_in,
  input wire logic               reset_n_in,
  input wire pfce_req_t          req_in,
  input wire logic               req_valid_in,
  input wire logic               req_ready_out,
  input wire pfce_rsp_t          rsp_out,
  input wire logic               rsp_valid_out,
  input wire pfce_pins_t         pins_out,
  input wire logic [PFCE_DW-1:0] data_lines_out,
  input wire logic               data_lines_oe_out,
  input wire logic [PFCE_DW-1:0] data_lines_in
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic took = req_valid_in && req_ready_out;
  property p_oe_gate; data_lines_oe_out |-> pins_out.oe_n; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("bus driven in read");
  property p_rd_sel; !pins_out.oe_n |-> !pins_out.ce_n && pins_out.we_n; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("bad read select");
  property p_wr_gate;
    !pins_out.we_n |-> !pins_out.ce_n && pins_out.oe_n && data_lines_oe_out;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write not gated");
  property p_addr_set;
    $fell(pins_out.we_n) |-> $stable(pins_out.addr) && $past(pins_out.ce_n) == 1'b0;
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address not set up");
  property p_data_hold;
    $rose(pins_out.we_n) |-> data_lines_oe_out && !pins_out.ce_n && $stable(data_lines_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held");
  property p_strobe; $fell(pins_out.we_n) |=> pins_out.we_n; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe length");
  property p_poll_after; $rose(pins_out.we_n) |-> pins_out.oe_n ##1 pins_out.oe_n; endproperty
  a_poll_after: assert property (p_poll_after) else $error("read too early");
  property p_one_req; took |=> !req_ready_out; endproperty
  a_one_req: assert property (p_one_req) else $error("ready while busy");
  property p_done; took |-> ##[1:1000] rsp_valid_out; endproperty
  a_done: assert property (p_done) else $error("no response");
  c_prog: cover property (took && req_in.op == PFCE_OP_PROG);
  c_query: cover property (took && req_in.op == PFCE_OP_QUERY);
  c_tmo: cover property (rsp_valid_out && rsp_out.timeout);
endmodule : pfce_host_properties

bind pfce_host pfce_host_properties #(.POLL_MAX(POLL_MAX)) chk_u (
  .clk_in, .reset_n_in, .req_in, .req_valid_in, .req_ready_out, .rsp_out,
  .rsp_valid_out, .pins_out, .data_lines_out, .data_lines_oe_out, .data_lines_in
);

// file: tb/pfce_flash_model.sv
// Behavioural flash device seen through the host controller's pins
`timescale 1ns/1ns
module pfce_flash_model
  import pfce_pkg::*;
(
  input  wire logic               ce_n_in,
  input  wire logic               oe_n_in,
  input  wire logic               we_n_in,
  input  wire logic [PFCE_AW-1:0] addr_in,
  input  wire logic [PFCE_DW-1:0] dq_in,
  input  wire logic               slow_in,
  output      logic [PFCE_DW-1:0] dq_out,
  output      logic               dq_oe_out,
  output      int                 viol_out
);
  logic [15:0]        mem [int];
  logic [PFCE_AW-1:0] a_lat;
  logic [15:0]        p_data = 16'h0000;
  logic [15:0]        last = 16'h0000;
  int                 step = 0;
  bit                 query = 0;
  bit                 tog = 0;
  bit                 is_prog = 0;
  time                done_at = 0;
  time                t_fall = 0;
  wire logic          wr_n = we_n_in | ce_n_in | ~oe_n_in;
  wire logic          rd_n = ce_n_in | oe_n_in;
  initial viol_out = 0;
  // Released bus shows the inverse, so a stale value never passes
  assign dq_oe_out = !rd_n;
  assign dq_out = rd_n ? ~last : last;
  function automatic logic [15:0] rd(input logic [PFCE_AW-1:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : rd
  task automatic erase(input int lsb);
    int q [$];
    foreach (mem[k]) if ((k >> lsb) == (a_lat >> lsb)) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
    is_prog = 0;
    step = 0;
    done_at = $time + 6000;
  endtask : erase
  always @(negedge wr_n) begin
    a_lat = addr_in;
    t_fall = $time;
  end
  always @(posedge wr_n) begin : wr_blk
    logic [7:0]  d;
    logic [14:0] a;
    d = dq_in[7:0];
    a = a_lat[14:0];
    if ($time - t_fall < 5) d = d;
    else if ($time < done_at) viol_out++;
    else if (step == 3) begin
      if (rd(a_lat) !== 16'hffff) viol_out++;
      mem[a_lat] = dq_in;
      p_data = dq_in;
      is_prog = 1;
      step = 0;
      done_at = $time + (slow_in ? 60000 : 3000);
    end
    else if (step == 6 && d == 8'h30) erase(11);
    else if (step == 6 && d == 8'h50) erase(15);
    else if (step == 6 && d == 8'h10 && a == 15'h5555) erase(19);
    else if (step == 2 && a == 15'h5555 && d == 8'ha0) step = 3;
    else if (step == 2 && a == 15'h5555 && d == 8'h80) step = 4;
    else if (step == 2 && a == 15'h5555 && d == 8'h98) begin
      query = 1;
      step = 0;
    end
    else if (d == 8'hf0) begin
      query = 0;
      step = 0;
    end
    else if (step inside {0, 1, 4, 5} && a == (step[0] ? 15'h2aaa : 15'h5555)
             && d == (step[0] ? 8'h55 : 8'haa)) step++;
    else step = 0;
  end
  always @(negedge rd_n) begin
    if ($time < done_at) begin
      tog = ~tog;
      last = is_prog ? {~p_data[15:7], tog, ~p_data[5:0]} : {9'h000, tog, 6'h00};
    end
    else if (is_prog && $time < done_at + 1000)
      last = {~p_data[15:8], p_data[7:6], ~p_data[5:0]};
    else if (query) last = (addr_in[7:0] == 8'h10) ? 16'h0051 : 16'h0000;
    else last = rd(addr_in);
  end
endmodule : pfce_flash_model

// file: tb/tb.sv
// Testbench: host controller against the behavioural flash device
`timescale 1ns/1ns
module tb;
  import pfce_pkg::*;
  logic               clk_in = 1'b0;
  logic               reset_n_in = 1'b0;
  pfce_req_t          req_in = '0;
  logic               req_valid_in = 1'b0;
  logic               slow = 1'b0;
  logic               req_ready_out;
  logic               rsp_valid_out;
  logic               data_lines_oe_out;
  pfce_rsp_t          rsp_out;
  pfce_rsp_t          r;
  pfce_pins_t         pins_out;
  logic [PFCE_DW-1:0] data_lines_out;
  logic [PFCE_DW-1:0] flash_dq;
  logic [PFCE_DW-1:0] data_lines_in;
  int                 viol;
  int                 bad_count = 0;
  int                 n_checks = 0;
  always #50 clk_in = ~clk_in;
  assign data_lines_in = data_lines_oe_out ? data_lines_out : flash_dq;
  pfce_host #(.POLL_MAX(50)) dut_u (.clk_in, .reset_n_in, .req_in, .req_valid_in,
    .req_ready_out, .rsp_out, .rsp_valid_out, .pins_out, .data_lines_out,
    .data_lines_oe_out, .data_lines_in);
  pfce_flash_model fm_u (.ce_n_in(pins_out.ce_n), .oe_n_in(pins_out.oe_n),
    .we_n_in(pins_out.we_n), .addr_in(pins_out.addr), .dq_in(data_lines_in),
    .slow_in(slow), .dq_out(flash_dq), .dq_oe_out(), .viol_out(viol));
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input pfce_op_t op, input logic [18:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1 n++;
    end
    @(posedge clk_in);
    req_in <= '{op, a, d};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 3000) begin
      bad_count++;
      close_out();
    end else begin
      r = rsp_out;
    end
  endtask : xfer
  task automatic rd_chk(input logic [18:0] a, input logic [15:0] e, input string nm);
    xfer(PFCE_OP_READ, a, 16'h0000);
    check(nm, r.data, e);
  endtask : rd_chk
  task automatic op_chk(input pfce_op_t op, input logic [18:0] a, input logic [15:0] d);
    xfer(op, a, d);
    check(op.name(), {r.ok, r.timeout}, 2'b10);
  endtask : op_chk
  task automatic t_program();
    logic [18:0] a [4] = '{19'h00123, 19'h00124, 19'h00923, 19'h08005};
    logic [15:0] d [4] = '{16'h5a3c, 16'h80c3, 16'h0f0f, 16'h7e81};
    for (int i = 0; i < 4; i++) begin
      op_chk(PFCE_OP_PROG, a[i], d[i]);
      rd_chk(a[i], d[i], "prog_word");
    end
  endtask : t_program
  task automatic t_erase();
    op_chk(PFCE_OP_SECT, 19'h00000, 16'h0000);
    rd_chk(19'h00123, 16'hffff, "sect_hit");
    rd_chk(19'h00923, 16'h0f0f, "sect_miss");
    op_chk(PFCE_OP_BLOCK, 19'h00000, 16'h0000);
    rd_chk(19'h00923, 16'hffff, "block_hit");
    rd_chk(19'h08005, 16'h7e81, "block_miss");
    op_chk(PFCE_OP_CHIP, 19'h00000, 16'h0000);
    rd_chk(19'h08005, 16'hffff, "chip_word");
  endtask : t_erase
  task automatic t_query();
    op_chk(PFCE_OP_QUERY, 19'h00000, 16'h0000);
    rd_chk(19'h00010, 16'h0051, "query_word");
    op_chk(PFCE_OP_EXIT, 19'h00000, 16'h0000);
    rd_chk(19'h00010, 16'hffff, "after_exit");
  endtask : t_query
  task automatic t_slow();
    int n;
    n = 0;
    slow <= 1'b1;
    xfer(PFCE_OP_PROG, 19'h10000, 16'h1234);
    check("slow_status", {r.ok, r.timeout}, 2'b01);
    do begin
      xfer(PFCE_OP_READ, 19'h10000, 16'h0000);
      n++;
    end while (r.data !== 16'h1234 && n < 60);
    check("slow_word", r.data, 16'h1234);
  endtask : t_slow
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_chk(19'h00100, 16'hffff, "blank_word");
    t_program();
    t_erase();
    t_query();
    t_slow();
    check("model_viol", viol, 0);
    close_out();
  end
  // Watchdog: a hung handshake still reaches the verdict
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
endmodule : tb
